//--- tss_cfg.svh
// Constants of the trigger stage sequencer
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// ============================================================
// Sizes
`define TSS_STAGES 4
`define TSS_STG_W 2
`define TSS_CLAUSES 4
`define TSS_WRS 4
`define TSS_CNTS 2
`define TSS_CSEL_W 1
`define TSS_EVS 6
`define TSS_BUS_W 24
`define TSS_CNT_W 16
`define TSS_DLY_W 16

// ============================================================
// Counter operations
`define TSS_OP_INC 2'h0
`define TSS_OP_CLR 2'h1
`define TSS_OP_DEC 2'h2

// ============================================================
// Reset values
`define TSS_STAGE_RST 2'h0
`define TSS_CNT_RST 16'h0000
`define TSS_DLY_RST 16'h0000

`endif

//--- tss_pkg.sv
// Types of the trigger stage sequencer
`include "tss_cfg.svh"

package tss_pkg;

  // ============================================================
  // Action group of one clause
  typedef struct packed {
    logic trig;
    logic [`TSS_DLY_W-1:0] trig_dly;
    logic store_gate_action;
    logic stage_jump_action;
    logic [`TSS_STG_W-1:0] jump_to;
    logic cnt_en;
    logic [`TSS_CSEL_W-1:0] cnt_sel;
    logic [1:0] cnt_op;
  } tss_action_type;

  typedef struct packed {
    logic used;
    logic combined;
    logic nested;
    logic [`TSS_EVS-1:0] members;
    logic [`TSS_EVS-1:0] invert;
    tss_action_type act;
  } tss_clause_type;

  typedef struct packed {
    logic used;
    logic else_used;
    tss_action_type else_act;
    tss_clause_type [`TSS_CLAUSES-1:0] clause;
  } tss_stage_type;

  typedef struct packed {
    logic [`TSS_BUS_W-1:0] value;
    logic [`TSS_BUS_W-1:0] care;
  } tss_wr_cfg_type;

  typedef struct packed {
    logic time_mode;
    logic [`TSS_CNT_W-1:0] limit;
  } tss_cnt_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_POST = 3'b100
  } tss_state_type;

endpackage : tss_pkg

//--- tss_sequencer.sv
// Trigger stage sequencer: event evaluation, stage walk and actions
`timescale 1ns/10ps
`default_nettype none
`include "tss_cfg.svh"

module tss_sequencer
  import tss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sut_clk,
  input wire logic [`TSS_BUS_W-1:0] sut_bus,
  input wire logic acq_start,
  input wire logic acq_abort,
  input wire tss_stage_type [`TSS_STAGES-1:0] prog,
  input wire tss_wr_cfg_type [`TSS_WRS-1:0] wr_cfg,
  input wire tss_cnt_cfg_type [`TSS_CNTS-1:0] cnt_cfg,
  output logic acq_running,
  output logic triggered,
  output logic acq_done,
  output logic store_strobe,
  output logic prog_error,
  output logic [`TSS_STG_W-1:0] active_stage,
  output logic [`TSS_EVS-1:0] event_state
);

  // ============================================================
  // Pin synchronisers
  logic [2:0] clk_sync_r;
  logic [2:0] clk_sync_nxt;
  logic [`TSS_BUS_W-1:0] bus_s1_r, bus_s2_r, bus_s3_r;
  logic clk_lvl_r;
  logic clk_lvl_nxt;
  logic tick;

  always_comb begin
    clk_sync_nxt = {clk_sync_r[1:0], sut_clk};
    clk_lvl_nxt = clk_lvl_r;
    tick = 1'b0;
    // Level accepted only once stages two and three agree
    if (clk_sync_r[2] == clk_sync_r[1]) begin
      clk_lvl_nxt = clk_sync_r[2];
      tick = clk_sync_r[2] & ~clk_lvl_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_sync_r <= 3'h0;
      clk_lvl_r <= 1'b0;
      bus_s1_r <= '0;
      bus_s2_r <= '0;
      bus_s3_r <= '0;
    end else begin
      clk_sync_r <= clk_sync_nxt;
      clk_lvl_r <= clk_lvl_nxt;
      bus_s1_r <= sut_bus;
      bus_s2_r <= bus_s1_r;
      bus_s3_r <= bus_s2_r;
    end
  end

  // ============================================================
  // Simple events
  logic [`TSS_WRS-1:0] wr_hit;
  logic [`TSS_CNTS-1:0] cnt_hit;
  logic [`TSS_CNT_W-1:0] cnt_r [`TSS_CNTS];
  logic [`TSS_EVS-1:0] ev;

  genvar gw;
  generate
    for (gw = 0; gw < `TSS_WRS; gw++) begin : g_wr
      // Bus travels the same three stages as the clock, so both line up
      assign wr_hit[gw] = ~|((bus_s3_r ^ wr_cfg[gw].value) & wr_cfg[gw].care);
    end
    for (gw = 0; gw < `TSS_CNTS; gw++) begin : g_cnt_ev
      assign cnt_hit[gw] = (cnt_r[gw] >= cnt_cfg[gw].limit);
    end
  endgenerate

  assign ev = {cnt_hit, wr_hit};

  // ============================================================
  // Program check
  logic prog_bad;

  always_comb begin
    prog_bad = 1'b0;
    for (int s = 0; s < `TSS_STAGES; s++) begin
      // Stages exist only in creation order
      if (s > 0 && prog[s].used && !prog[s-1].used) begin
        prog_bad = 1'b1;
      end
      if (prog[s].used) begin
        for (int c = 0; c < `TSS_CLAUSES; c++) begin
          if (prog[s].clause[c].used) begin
            if (prog[s].clause[c].nested) begin
              prog_bad = 1'b1;
            end
            if (!prog[s].clause[c].combined && |prog[s].clause[c].invert) begin
              prog_bad = 1'b1;
            end
            if (prog[s].clause[c].act.stage_jump_action &&
                !prog[prog[s].clause[c].act.jump_to].used) begin
              prog_bad = 1'b1;
            end
          end
        end
        if (prog[s].else_used && prog[s].else_act.stage_jump_action &&
            !prog[prog[s].else_act.jump_to].used) begin
          prog_bad = 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Clause evaluation of the active stage
  tss_state_type state_r;
  tss_state_type state_nxt;
  logic [`TSS_STG_W-1:0] stage_r;
  logic [`TSS_CLAUSES:0] fire;
  tss_action_type acts [`TSS_CLAUSES+1];
  logic store_used;

  always_comb begin
    store_used = 1'b0;
    for (int s = 0; s < `TSS_STAGES; s++) begin
      store_used = store_used | (prog[s].else_used & prog[s].else_act.store_gate_action);
      for (int c = 0; c < `TSS_CLAUSES; c++) begin
        store_used = store_used |
          (prog[s].clause[c].used & prog[s].clause[c].act.store_gate_action);
      end
    end
  end

  always_comb begin
    fire = '0;
    // Only the active stage is looked at
    for (int c = 0; c < `TSS_CLAUSES; c++) begin
      acts[c] = prog[stage_r].clause[c].act;
      if (prog[stage_r].clause[c].used) begin
        if (prog[stage_r].clause[c].combined) begin
          fire[c] = |((ev ^ prog[stage_r].clause[c].invert) &
                      prog[stage_r].clause[c].members);
        end else begin
          fire[c] = |(ev & prog[stage_r].clause[c].members);
        end
      end
    end
    // Single fallback slot per stage
    acts[`TSS_CLAUSES] = prog[stage_r].else_act;
    fire[`TSS_CLAUSES] = prog[stage_r].else_used & ~|fire[`TSS_CLAUSES-1:0];
  end

  // ============================================================
  // Action merge with earliest-wins on conflicts
  logic do_trig;
  logic [`TSS_DLY_W-1:0] trig_dly;
  logic do_store;
  logic do_jump;
  logic [`TSS_STG_W-1:0] jump_to;
  logic [`TSS_CNTS-1:0] cnt_taken;
  logic [1:0] cnt_op [`TSS_CNTS];

  always_comb begin
    do_trig = 1'b0;
    trig_dly = `TSS_DLY_RST;
    do_store = 1'b0;
    do_jump = 1'b0;
    jump_to = stage_r;
    cnt_taken = '0;
    for (int k = 0; k < `TSS_CNTS; k++) begin
      cnt_op[k] = `TSS_OP_INC;
    end
    // All true clauses act in the same state clock
    for (int c = 0; c <= `TSS_CLAUSES; c++) begin
      if (fire[c]) begin
        if (acts[c].trig && !do_trig) begin
          do_trig = 1'b1;
          trig_dly = acts[c].trig_dly;
        end
        do_store = do_store | acts[c].store_gate_action;
        if (acts[c].stage_jump_action && !do_jump) begin
          do_jump = 1'b1;
          jump_to = acts[c].jump_to;
        end
        if (acts[c].cnt_en && !cnt_taken[acts[c].cnt_sel]) begin
          cnt_taken[acts[c].cnt_sel] = 1'b1;
          cnt_op[acts[c].cnt_sel] = acts[c].cnt_op;
        end
      end
    end
  end

  // ============================================================
  // Sequencer state
  logic [`TSS_STG_W-1:0] stage_nxt;
  logic [`TSS_DLY_W-1:0] dly_r;
  logic [`TSS_DLY_W-1:0] dly_nxt;
  logic [`TSS_CNT_W-1:0] cnt_nxt [`TSS_CNTS];
  logic running;
  logic act_tick;
  logic done_nxt;
  logic trig_nxt;
  logic store_nxt;

  assign running = (state_r == ST_RUN) || (state_r == ST_POST);
  assign act_tick = tick & running;

  always_comb begin
    state_nxt = state_r;
    stage_nxt = stage_r;
    dly_nxt = dly_r;
    done_nxt = acq_done;
    trig_nxt = triggered;
    store_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (acq_start && !prog_bad) begin
          state_nxt = ST_RUN;
          stage_nxt = `TSS_STAGE_RST;
          dly_nxt = `TSS_DLY_RST;
          done_nxt = 1'b0;
          trig_nxt = 1'b0;
        end
      end
      ST_RUN: begin
        if (act_tick && do_trig) begin
          state_nxt = ST_POST;
          dly_nxt = trig_dly;
          trig_nxt = 1'b1;
        end
      end
      ST_POST: begin
        // Delay counted in state clocks after the trigger
        if (tick) begin
          if (dly_r == `TSS_DLY_RST) begin
            state_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            dly_nxt = dly_r - 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (act_tick) begin
      // Without any store action every sample is kept
      store_nxt = do_store | ~store_used;
      if (do_jump) begin
        stage_nxt = jump_to;
      end
    end
    if (acq_abort && running) begin
      state_nxt = ST_IDLE;
      done_nxt = 1'b1;
    end
  end

  // ============================================================
  // Counters
  always_comb begin
    for (int k = 0; k < `TSS_CNTS; k++) begin
      cnt_nxt[k] = cnt_r[k];
      if (state_r == ST_IDLE && acq_start && !prog_bad) begin
        cnt_nxt[k] = `TSS_CNT_RST;
      end else if (running) begin
        // Time base is the system clock, so elapsed time runs between state clocks
        if (cnt_cfg[k].time_mode && !cnt_hit[k]) begin
          cnt_nxt[k] = cnt_r[k] + 1'b1;
        end
        if (act_tick && cnt_taken[k]) begin
          case (cnt_op[k])
            `TSS_OP_INC: begin
              if (cnt_r[k] != '1) begin
                cnt_nxt[k] = cnt_r[k] + 1'b1;
              end
            end
            `TSS_OP_CLR: begin
              cnt_nxt[k] = `TSS_CNT_RST;
            end
            `TSS_OP_DEC: begin
              if (cnt_r[k] != '0) begin
                cnt_nxt[k] = cnt_r[k] - 1'b1;
              end
            end
            default: begin
              cnt_nxt[k] = cnt_r[k];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      stage_r <= `TSS_STAGE_RST;
      dly_r <= `TSS_DLY_RST;
      for (int k = 0; k < `TSS_CNTS; k++) begin
        cnt_r[k] <= `TSS_CNT_RST;
      end
    end else begin
      state_r <= state_nxt;
      stage_r <= stage_nxt;
      dly_r <= dly_nxt;
      for (int k = 0; k < `TSS_CNTS; k++) begin
        cnt_r[k] <= cnt_nxt[k];
      end
    end
  end

  // ============================================================
  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acq_running <= 1'b0;
      triggered <= 1'b0;
      acq_done <= 1'b0;
      store_strobe <= 1'b0;
      prog_error <= 1'b0;
      active_stage <= `TSS_STAGE_RST;
      event_state <= '0;
    end else begin
      acq_running <= (state_nxt == ST_RUN) || (state_nxt == ST_POST);
      triggered <= trig_nxt;
      acq_done <= done_nxt;
      store_strobe <= store_nxt;
      prog_error <= prog_bad;
      active_stage <= stage_nxt;
      event_state <= ev;
    end
  end

endmodule : tss_sequencer
`default_nettype wire

//--- tss_monitor.sv
// Port checker of the trigger stage sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tss_cfg.svh"
module tss_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic acq_start,
  input wire logic acq_abort,
  input wire logic acq_running,
  input wire logic triggered,
  input wire logic acq_done,
  input wire logic store_strobe,
  input wire logic prog_error,
  input wire logic [`TSS_STG_W-1:0] active_stage
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ======
  // Control
  // Start right after reset is skipped: the program check is not settled yet
  start_takes_a: assert property (!$past(rst) && !acq_running && acq_start && !prog_error |=>
    acq_running && !triggered && !acq_done && active_stage == 2'h0)
    else $error("start not taken cleanly");
  refuse_bad_a: assert property (!acq_running && acq_start && prog_error |=> !acq_running)
    else $error("invalid program started");
  abort_stop_a: assert property (acq_running && acq_abort |=> !acq_running && acq_done)
    else $error("abort did not stop");
  done_low_a: assert property (acq_running |-> !acq_done)
    else $error("done while running");
  end_done_a: assert property ($fell(acq_running) |-> acq_done && (triggered || $past(acq_abort)))
    else $error("stop without trigger or abort");
  // ======
  // Trigger and sequencing
  trig_run_a: assert property ($rose(triggered) |-> acq_running)
    else $error("trigger outside a run");
  trig_hold_a: assert property (triggered && acq_running |=> triggered)
    else $error("trigger flag lost in a run");
  strobe_single_a: assert property (store_strobe |=> !store_strobe)
    else $error("store strobe longer than one cycle");
  strobe_running_a: assert property (store_strobe |-> $past(acq_running))
    else $error("store strobe while idle");
  stage_idle_a: assert property (!acq_running && !$past(acq_running) |-> $stable(active_stage))
    else $error("stage moved while idle");
endmodule : tss_monitor
bind tss_sequencer tss_monitor tss_monitor_i (.sys_clk(sys_clk), .rst(rst), .acq_start(acq_start),
  .acq_abort(acq_abort), .acq_running(acq_running), .triggered(triggered), .acq_done(acq_done),
  .store_strobe(store_strobe), .prog_error(prog_error), .active_stage(active_stage));
`default_nettype wire

//--- tss_sut_model.sv
// Probed bus model: one state clock per beat
`timescale 1ns/10ps
`default_nettype none
`include "tss_cfg.svh"
module tss_sut_model (
  input wire logic sys_clk,
  output logic sut_clk,
  output logic [`TSS_BUS_W-1:0] sut_bus
);
  initial begin
    sut_clk = 1'b0;
    sut_bus = 24'h000000;
  end
  // ======
  // Beat
  // Clock stands still between beats; bus is scrambled for a cycle once its hold is over
  task automatic beat(input logic [`TSS_BUS_W-1:0] w);
    sut_bus = w;
    repeat (3) @(negedge sys_clk);
    sut_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
    sut_clk = 1'b0;
    repeat (2) @(negedge sys_clk);
    sut_bus = ~w;
    @(negedge sys_clk);
  endtask : beat
endmodule : tss_sut_model
`default_nettype wire

//--- test_trigger_stage_sequencer.sv
// Self-checking bench of the trigger stage sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tss_cfg.svh"
module test_trigger_stage_sequencer import tss_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic acq_start = 1'b0;
  logic acq_abort = 1'b0;
  tss_stage_type [`TSS_STAGES-1:0] prog = '0;
  tss_wr_cfg_type [`TSS_WRS-1:0] wr_cfg = '0;
  tss_cnt_cfg_type [`TSS_CNTS-1:0] cnt_cfg = '0;
  wire logic sut_clk;
  wire logic [`TSS_BUS_W-1:0] sut_bus;
  logic acq_running, triggered, acq_done, store_strobe, prog_error;
  logic [`TSS_STG_W-1:0] active_stage;
  logic [`TSS_EVS-1:0] event_state;
  int fail_count = 0;
  int samples_checked = 0;
  logic [2:0] notes[$];
  logic [2:0] nt;
  logic [23:0] rw;
  always #50 sys_clk = ~sys_clk;
  tss_sequencer tss_sequencer_i (.sys_clk(sys_clk), .rst(rst), .sut_clk(sut_clk),
    .sut_bus(sut_bus), .acq_start(acq_start), .acq_abort(acq_abort), .prog(prog),
    .wr_cfg(wr_cfg), .cnt_cfg(cnt_cfg), .acq_running(acq_running), .triggered(triggered),
    .acq_done(acq_done), .store_strobe(store_strobe), .prog_error(prog_error),
    .active_stage(active_stage), .event_state(event_state));
  tss_sut_model tss_sut_model_i (.sys_clk(sys_clk), .sut_clk(sut_clk), .sut_bus(sut_bus));
  // ======
  // Helpers
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic cl(input int s, input int c, input logic [5:0] m, input logic [1:0] t,
      input logic tr);
    prog[s].used = 1'b1;
    prog[s].clause[c].used = 1'b1;
    prog[s].clause[c].combined = ($countones(m) > 1);
    prog[s].clause[c].members = m;
    prog[s].clause[c].act.stage_jump_action = 1'b1;
    prog[s].clause[c].act.jump_to = t;
    prog[s].clause[c].act.trig = tr;
    prog[s].clause[c].act.trig_dly = 16'h0001;
  endtask : cl
  task automatic go(input logic [23:0] w, input logic [2:0] e);
    notes.push_back(e);
    tss_sut_model_i.beat(w);
  endtask : go
  task automatic pulse_start;
    acq_start = 1'b1;
    @(negedge sys_clk);
    acq_start = 1'b0;
    @(negedge sys_clk);
  endtask : pulse_start
  // ======
  // Result watcher: each store strobe settles the oldest note
  always @(negedge sys_clk) begin
    if (store_strobe === 1'b1) begin
      if (notes.size() > 0) begin
        nt = notes.pop_front();
        cmp("active_stage", {22'h0, nt[1:0]}, {22'h0, active_stage});
        cmp("triggered", {23'h0, nt[2]}, {23'h0, triggered});
      end else begin
        cmp("unexpected store_strobe", 24'h0, {23'h0, store_strobe});
      end
    end
  end
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
  // ======
  // Main sequence
  initial begin
    void'($urandom(32'h0034));
    wr_cfg[0] = '{24'h123456, 24'hffffff};
    wr_cfg[1] = '{24'h000056, 24'h0000ff};
    wr_cfg[2] = '{24'hab0000, 24'hff0000};
    wr_cfg[3] = '{24'h7e7e7e, 24'hffffff};
    cnt_cfg[0] = '{1'b1, 16'h0014};
    cl(0, 0, 6'h01, 2'h1, 1'b0);
    cl(0, 1, 6'h02, 2'h2, 1'b0);
    cl(1, 0, 6'h0c, 2'h3, 1'b0);
    cl(2, 0, 6'h08, 2'h0, 1'b0);
    cl(3, 0, 6'h08, 2'h0, 1'b1);
    prog[1].else_used = 1'b1;
    prog[1].else_act.stage_jump_action = 1'b1;
    prog[1].else_act.jump_to = 2'h2;
    prog[0].clause[2].used = 1'b1;
    prog[0].clause[2].nested = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    cmp("prog_error", 24'h1, {23'h0, prog_error});
    pulse_start();
    cmp("acq_running", 24'h0, {23'h0, acq_running});
    prog[0].clause[2] = '0;
    repeat (3) @(negedge sys_clk);
    pulse_start();
    cmp("acq_running", 24'h1, {23'h0, acq_running});
    cmp("counter event", 24'h0, {23'h0, event_state[4]});
    rw = {8'h11, 8'($urandom()), 8'h00};
    go(rw, 3'h0);
    go(24'h999956, 3'h2);
    go(24'hab0000, 3'h2);
    go(24'h7e7e7e, 3'h0);
    go(24'h123456, 3'h1);
    rw = {8'h11, 8'($urandom()), 8'h00};
    go(rw, 3'h2);
    go(24'h7e7e7e, 3'h0);
    go(24'h123456, 3'h1);
    go(24'hab1234, 3'h3);
    go(24'h7e7e7e, 3'h4);
    cmp("counter event", 24'h1, {23'h0, event_state[4]});
    go(24'h111100, 3'h4);
    cmp("acq_running", 24'h1, {23'h0, acq_running});
    go(24'h111100, 3'h4);
    cmp("acq_done", 24'h1, {23'h0, acq_done});
    pulse_start();
    cmp("triggered", 24'h0, {23'h0, triggered});
    go(24'h999956, 3'h2);
    acq_abort = 1'b1;
    @(negedge sys_clk);
    acq_abort = 1'b0;
    cmp("acq_done", 24'h1, {23'h0, acq_done});
    tss_sut_model_i.beat(24'h7e7e7e);
    cmp("active_stage", 24'h2, {22'h0, active_stage});
    // ======
    // Store gating, inverted members and counting counter
    prog = '0;
    cnt_cfg[1] = '{1'b0, 16'h0002};
    prog[0].used = 1'b1;
    prog[0].clause[0].used = 1'b1;
    prog[0].clause[0].combined = 1'b1;
    prog[0].clause[0].members = 6'h08;
    prog[0].clause[0].invert = 6'h08;
    prog[0].clause[0].act.store_gate_action = 1'b1;
    prog[0].clause[0].act.cnt_en = 1'b1;
    prog[0].clause[0].act.cnt_sel = 1'b1;
    prog[0].clause[0].act.cnt_op = `TSS_OP_INC;
    prog[0].clause[2] = prog[0].clause[0];
    prog[0].clause[2].members = 6'h20;
    prog[0].clause[2].invert = 6'h20;
    prog[0].clause[2].act.store_gate_action = 1'b0;
    prog[0].clause[2].act.cnt_op = `TSS_OP_CLR;
    prog[0].clause[1].used = 1'b1;
    prog[0].clause[1].members = 6'h20;
    prog[0].clause[1].act.trig = 1'b1;
    pulse_start();
    tss_sut_model_i.beat(24'h7e7e7e);
    rw = {8'h11, 8'($urandom()), 8'h00};
    go(rw, 3'h0);
    go(rw, 3'h0);
    tss_sut_model_i.beat(24'h7e7e7e);
    cmp("triggered", 24'h1, {23'h0, triggered});
    cmp("acq_running", 24'h1, {23'h0, acq_running});
    go(rw, 3'h4);
    cmp("acq_done", 24'h1, {23'h0, acq_done});
    cmp("notes left", 24'h0, 24'(notes.size()));
    test_done();
  end
endmodule : test_trigger_stage_sequencer
`default_nettype wire
